/* File: dv/remote_access_rest_time_sampler_tb.sv */
// Self-checking bench for the rest time sampler.
`timescale 1ns/10ps
module remote_access_rest_time_sampler_tb
  import rest_sampler_pkg::*;
;
  logic mclk, rst, coreClockHalfSelect, transferAcknowledge, writeDone, accessValid, targetSelect;
  logic coreTick, oscillatorClockOut, accessActive, accessStart, accessEnd, selControlReg, writePending_n;
  acc_mode_type accMode;
  logic [1:0] memSelect, targetMem;
  int error_cnt = 0, total_checks = 0, startCnt = 0;
  typedef struct {acc_mode_type m; logic h, s; logic [1:0] ms; logic es; logic [1:0] em;} row_type;
  row_type rows [4] = '{'{MODE_NORMAL, 1'b0, 1'b1, 2'h2, 1'b1, 2'h2}, '{MODE_LATCHED_READ, 1'b0, 1'b0, 2'h1, 1'b0, 2'h1},
    '{MODE_FAST_BUF_WRITE, 1'b0, 1'b1, 2'h3, 1'b1, 2'h3}, '{MODE_NORMAL, 1'b1, 1'b0, 2'h0, 1'b0, 2'h0}};
  remote_access_rest_time_sampler u_remote_access_rest_time_sampler (.mclk(mclk), .rst(rst),
    .coreClockHalfSelect(coreClockHalfSelect), .accMode(accMode), .memSelect(memSelect), .accessValid(accessValid),
    .targetSelect(targetSelect), .transferAcknowledge(transferAcknowledge), .writeDone(writeDone), .coreTick(coreTick),
    .oscillatorClockOut(oscillatorClockOut), .accessActive(accessActive), .accessStart(accessStart),
    .accessEnd(accessEnd), .selControlReg(selControlReg), .targetMem(targetMem), .writePending_n(writePending_n));
  remote_host_model u_remote_host_model (.mclk(mclk), .accessValid(accessValid), .targetSelect(targetSelect));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (accessStart === 1'b1) startCnt++;
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    coreClockHalfSelect = 1'b0;
    accMode = MODE_NORMAL;
    memSelect = 2'h0;
    transferAcknowledge = 1'b0;
    writeDone = 1'b0;
    repeat (8) @(posedge mclk);
    chk({accessStart, selControlReg}, 2'h0);
    chk({writePending_n, accessActive}, 2'h2);
    rst <= 1'b0;
    foreach (rows[i]) begin
      accMode <= rows[i].m;
      coreClockHalfSelect <= rows[i].h;
      memSelect <= rows[i].ms;
      transferAcknowledge <= 1'b1;
      @(posedge mclk);
      transferAcknowledge <= 1'b0;
      repeat (3) @(posedge mclk);
      u_remote_host_model.access(rows[i].s, 4, 8);
      chk(selControlReg, rows[i].es);
      chk(targetMem, rows[i].em);
    end
    accMode <= MODE_NORMAL;
    coreClockHalfSelect <= 1'b0;
    startCnt = 0;
    // Continuous valid across a select change must stay one access.
    u_remote_host_model.access(1'b0, 3, 0);
    u_remote_host_model.access(1'b1, 3, 10);
    chk(startCnt[1:0], 2'h1);
    chk(selControlReg, 1'b0);
    u_remote_host_model.access(1'b0, 3, 1);
    u_remote_host_model.access(1'b1, 3, 10);
    chk(startCnt[1:0], 2'h3);
    chk(selControlReg, 1'b0);
    accMode <= MODE_LATCHED_WRITE;
    u_remote_host_model.access(1'b1, 3, 6);
    chk(writePending_n, 1'b0);
    writeDone <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(writePending_n, 1'b1);
    chk(selControlReg, 1'b0);
    results();
  end
  initial begin
    #200000;
    error_cnt++;
    results();
  end
endmodule // remote_access_rest_time_sampler_tb
bind remote_access_rest_time_sampler rest_sampler_props u_rest_sampler_props (.mclk(mclk), .rst(rst),
  .coreClockHalfSelect(coreClockHalfSelect), .accMode(accMode), .coreTick(coreTick),
  .oscillatorClockOut(oscillatorClockOut), .accessActive(accessActive), .accessStart(accessStart),
  .accessEnd(accessEnd), .selControlReg(selControlReg), .writePending_n(writePending_n));

/* File: dv/remote_host_model.sv */
// Behavioural remote host driving access cycles.
`timescale 1ns/10ps
module remote_host_model (
  // Clock
  input wire logic mclk,
  // Access pins
  output logic accessValid,
  output logic targetSelect
);
  initial begin
    accessValid = 1'b0;
    targetSelect = 1'b0;
  end
  // A zero gap keeps valid high, which breaks the rest time on purpose.
  task automatic access(input logic sel, input int len, input int gap);
    accessValid <= 1'b1;
    targetSelect <= sel;
    repeat (len) @(posedge mclk);
    if (gap > 0) begin
      accessValid <= 1'b0;
      targetSelect <= ~sel;
      repeat (gap) @(posedge mclk);
    end
  endtask
endmodule // remote_host_model

/* File: dv/rest_sampler_props.sv */
// Port checks for the rest time sampler.
`timescale 1ns/10ps
module rest_sampler_props
  import rest_sampler_pkg::*;
(
  // Watched ports
  input wire logic mclk,
  input wire logic rst,
  input wire logic coreClockHalfSelect,
  input wire acc_mode_type accMode,
  input wire logic coreTick,
  input wire logic oscillatorClockOut,
  input wire logic accessActive,
  input wire logic accessStart,
  input wire logic accessEnd,
  input wire logic selControlReg,
  input wire logic writePending_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence pendHeld;
    !writePending_n [*2];
  endsequence
  a_start_end_excl: assert property (!(accessStart && accessEnd))
    else $error("start and end together");
  a_start_active: assert property (accessStart |=> accessActive)
    else $error("start without active");
  a_sel_latch: assert property ($changed(selControlReg) && accMode != MODE_LATCHED_WRITE |-> accessStart)
    else $error("select moved mid access");
  a_pend_idle: assert property (accMode != MODE_LATCHED_WRITE |-> writePending_n)
    else $error("pending outside latched write");
  a_pend_low: assert property (accessStart && accMode == MODE_LATCHED_WRITE |-> ##[0:1] !writePending_n)
    else $error("pending not low");
  a_pend_min: assert property (accessEnd && accMode == MODE_LATCHED_WRITE |=> pendHeld)
    else $error("pending rose early");
  a_tick_full: assert property (!coreClockHalfSelect && $past(coreClockHalfSelect, 2) == 1'b0 && $past(rst, 2) == 1'b0
    |-> coreTick)
    else $error("full rate tick missing");
  a_tick_half: assert property (coreTick && coreClockHalfSelect && $past(coreClockHalfSelect) |=> !coreTick)
    else $error("half rate tick doubled");
  a_osc_toggle: assert property ($past(rst) == 1'b0 |-> oscillatorClockOut != $past(oscillatorClockOut))
    else $error("clock out stalled");
endmodule // rest_sampler_props

/* File: rtl/remote_access_rest_time_sampler.sv */
// Remote access recognition: validity sampling, end detection and target-select latching.
// Operation
// RULE_01 - Sample access validity at each T-state start; hold it for the T-state.
// RULE_02 - Host leaves at least 1T plus setup and hold between accesses.
// RULE_03 - Latched read and fast buffered write skip first sample after acknowledge rises.
// RULE_04 - Host ending soon after acknowledge extends its gap by up to 1T.
// RULE_05 - End then start one T-state later is one continued access. The code pulses accessStart again for such a start.
// RULE_06 - Select high targets control register; low targets memory-select bits.
// RULE_07 - Latch target select once at access start; hold for the access.
// RULE_08 - New access within 1.5T after end reuses the previous select.
// RULE_09 - The 1.5T guard starts when the end is first sampled.
// RULE_10 - Latched write accepts a new access start while write pending is low.
// RULE_11 - Latched write samples select for the next access when pending rises.
// RULE_12 - Latched write access within 0.5T after pending rises keeps old select.
// RULE_13 - Half-select low: core at oscillator rate; high: half rate, clock out full.
// RULE_14 - One T-state is one core cycle; intervals count core cycles.
// RULE_15 - Write pending rises no sooner than 3T after the access ended.
`timescale 1ns/10ps
`include "rest_sampler_map.svh"
module remote_access_rest_time_sampler
  import rest_sampler_pkg::*;
#(
  parameter int MEMSEL_W = `RS_MEMSEL_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration
  input wire logic coreClockHalfSelect,
  input wire acc_mode_type accMode,
  input wire logic [MEMSEL_W-1:0] memSelect,
  // Remote access pins
  input wire logic accessValid,
  input wire logic targetSelect,
  input wire logic transferAcknowledge,
  input wire logic writeDone,
  // Status
  output logic coreTick,
  output logic oscillatorClockOut,
  output logic accessActive,
  output logic accessStart,
  output logic accessEnd,
  output logic selControlReg,
  output logic [MEMSEL_W-1:0] targetMem,
  output logic writePending_n
);
  if (MEMSEL_W < 1) begin : g_bad_memsel
    $error("MEMSEL_W must be at least 1");
  end

  // ------------------------------------------------------------
  // Core clock enable
  // ------------------------------------------------------------
  // One enable per core cycle; full rate ticks every mclk, half rate every other.
  logic halfPhase_r;
  logic coreEn;
  assign coreEn = !coreClockHalfSelect || halfPhase_r; // RULE_13
  always_ff @(posedge mclk) begin
    if (rst) begin
      halfPhase_r <= 1'b0;
      oscillatorClockOut <= 1'b0;
      coreTick <= 1'b0;
    end else begin
      halfPhase_r <= !halfPhase_r;
      oscillatorClockOut <= !oscillatorClockOut; // RULE_13
      coreTick <= coreEn;
    end
  end

  // ------------------------------------------------------------
  // Validity sampling
  // ------------------------------------------------------------
  logic ackPrev_r;
  logic skipNext_r;
  logic sampled_r;
  logic delayedMode;
  logic ackRise;
  logic sampleNow;
  assign delayedMode = (accMode == MODE_LATCHED_READ) || (accMode == MODE_FAST_BUF_WRITE);
  assign ackRise = transferAcknowledge && !ackPrev_r;
  // The skipped edge is the first core edge after the mclk edge that sees acknowledge rise.
  assign sampleNow = coreEn && !(skipNext_r && delayedMode); // RULE_03 RULE_14
  always_ff @(posedge mclk) begin
    if (rst) begin
      ackPrev_r <= 1'b0;
      skipNext_r <= 1'b0;
      sampled_r <= 1'b0;
    end else begin
      ackPrev_r <= transferAcknowledge;
      if (ackRise) skipNext_r <= 1'b1;
      else if (coreEn) skipNext_r <= 1'b0; // RULE_03
      if (sampleNow) sampled_r <= accessValid; // RULE_01
    end
  end

  // ------------------------------------------------------------
  // Access sequencing
  // ------------------------------------------------------------
  acc_state_type state_r, state_nxt;
  logic [`RS_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [MEMSEL_W-1:0] targetMem_nxt;
  logic selControlReg_nxt;
  logic wpN_nxt;
  logic wpPrev_r;
  logic wpRise;
  logic lwSelOpen_r;
  logic newStart;
  logic endSeen;
  // A new start is seen only on a fresh sample; a valid sample straight after an end is a new start.
  assign newStart = sampleNow && accessValid && !sampled_r;
  assign endSeen = sampleNow && !accessValid && sampled_r;
  assign wpRise = writePending_n && !wpPrev_r;

  // ------------------------------------------------------------
  // Guard and pending decode
  // ------------------------------------------------------------
  logic lwMode;
  logic guardDone;
  logic [`RS_CNT_W-1:0] guardStep;
  logic pendCount;
  logic pendReady;
  logic lwHoldSel;
  assign lwMode = (accMode == MODE_LATCHED_WRITE);
  // The guard counts half T-states; at full rate one mclk is a whole T-state, so it steps twice as far.
  assign guardStep = coreClockHalfSelect ? `RS_CNT_W'(`RS_GUARD_STEP_HALF) : `RS_CNT_W'(`RS_GUARD_STEP_FULL); // RULE_08
  assign guardDone = (cnt_r >= `RS_CNT_W'(`RS_GUARD_HALF_T)); // RULE_09
  assign pendCount = coreEn && (cnt_r < `RS_CNT_W'(`RS_WP_MIN_T)); // RULE_15
  assign pendReady = writeDone && (cnt_r >= `RS_CNT_W'(`RS_WP_MIN_T)); // RULE_15
  assign lwHoldSel = (state_r == ST_IDLE) && lwSelOpen_r && newStart; // RULE_12

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    selControlReg_nxt = selControlReg;
    targetMem_nxt = targetMem;
    wpN_nxt = writePending_n;
    case (state_r)
      ST_IDLE: begin
        if (newStart) begin
          state_nxt = ST_ACCESS;
          selControlReg_nxt = targetSelect; // RULE_06 RULE_07
          targetMem_nxt = memSelect;
          if (lwMode) wpN_nxt = 1'b0;
        end
      end
      ST_ACCESS: begin
        if (endSeen) begin
          cnt_nxt = '0; // RULE_09
          state_nxt = lwMode ? ST_PEND : ST_GUARD;
        end
      end
      ST_GUARD: begin
        // Half-T counting: 1.5T is three half-T steps.
        if (newStart) begin
          state_nxt = ST_ACCESS; // RULE_08
        end else if (guardDone) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + guardStep;
        end
      end
      ST_PEND: begin
        // New starts during pending keep the access going; select comes at pending rise.
        if (newStart) state_nxt = ST_ACCESS; // RULE_10
        if (pendCount) cnt_nxt = cnt_r + `RS_CNT_W'(1);
        if (pendReady) begin
          wpN_nxt = 1'b1; // RULE_15
          selControlReg_nxt = targetSelect; // RULE_11
          targetMem_nxt = memSelect;
          if (!newStart) state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // Start shortly after pending rose keeps the value taken at the rise.
    if (lwHoldSel) begin
      selControlReg_nxt = selControlReg; // RULE_12
      targetMem_nxt = targetMem;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      selControlReg <= 1'b0;
      targetMem <= MEMSEL_W'(`RS_MEMSEL_RST);
      writePending_n <= 1'b1;
      wpPrev_r <= 1'b1;
      lwSelOpen_r <= 1'b0;
      accessActive <= 1'b0;
      accessStart <= 1'b0;
      accessEnd <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      selControlReg <= selControlReg_nxt;
      targetMem <= targetMem_nxt;
      writePending_n <= wpN_nxt;
      wpPrev_r <= writePending_n;
      if (wpRise) lwSelOpen_r <= 1'b1;
      else if (coreEn) lwSelOpen_r <= 1'b0; // RULE_12
      accessActive <= sampled_r; // RULE_01
      accessStart <= newStart && (state_r != ST_ACCESS); // RULE_05
      accessEnd <= endSeen;
    end
  end
endmodule // remote_access_rest_time_sampler

/* File: rtl/rest_sampler_map.svh */
// Constants for the remote access rest time sampler.
`ifndef REST_SAMPLER_MAP_SVH
`define REST_SAMPLER_MAP_SVH
`define RS_MEMSEL_W 2
`define RS_MEMSEL_RST 2'h0
`define RS_GUARD_HALF_T 3
`define RS_GUARD_STEP_FULL 2
`define RS_GUARD_STEP_HALF 1
`define RS_LW_GUARD_HALF_T 1
`define RS_WP_MIN_T 3
`define RS_CNT_W 3
`endif

/* File: rtl/rest_sampler_pkg.sv */
// Types for the remote access rest time sampler.
package rest_sampler_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACCESS = 4'h2,
    ST_GUARD = 4'h4,
    ST_PEND = 4'h8
  } acc_state_type;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_LATCHED_READ = 2'h1,
    MODE_FAST_BUF_WRITE = 2'h2,
    MODE_LATCHED_WRITE = 2'h3
  } acc_mode_type;
endpackage
